// file: ppi_top.sv
// pin interrupt logic and pad control for ports a, b and c
// Function
// - low A/B nibbles, all C pins interrupt-capable
// - per-pin select bit enables detection
// - per-port mode: edge or edge-and-level
// - per-pin polarity: falling/low or rising/high
// - synchronous edges, need prior deasserted level
// - falling edge is high then low sample
// - rising edge is low then high sample
// - edge-only: any enabled edge sets flag
// - flag and enable raise cpu request
// - edge-only: acknowledge one clears flag
// - level mode: edge or level sets flag
// - level mode: clear only when all deasserted
// - level mode: asserted pin keeps flag set
// - reset leaves pins input, pulls off
// - peripheral owns output enable; direction steers reads
// - drive strength, slew for outputs; pulls for inputs
// - pull enable ignored for outputs
module ppi_top (
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	input  wire ppi_pkg::ppi_power_t           power_mode,
	input  wire logic [ppi_pkg::PORT_W-1:0]    pin_in_a,
	input  wire logic [ppi_pkg::PORT_W-1:0]    pin_in_b,
	input  wire logic [ppi_pkg::PORT_W-1:0]    pin_in_c,
	input  wire logic [ppi_pkg::NUM_PORTS-1:0] ctrl_write,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_data_out,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_direction,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_pull_enable,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_slew_enable,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_drive_strength,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_pin_irq_select,
	input  wire logic [ppi_pkg::PORT_W-1:0]    wr_edge_polarity,
	input  wire logic                          wr_detect_mode,
	input  wire logic                          wr_irq_enable,
	input  wire logic [ppi_pkg::NUM_PORTS-1:0] port_irq_acknowledge,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_own_a,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_oe_a,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_out_a,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_own_b,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_oe_b,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_out_b,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_own_c,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_oe_c,
	input  wire logic [ppi_pkg::PORT_W-1:0]    periph_out_c,
	output logic [ppi_pkg::PORT_W-1:0]         pin_out_a,
	output logic [ppi_pkg::PORT_W-1:0]         pin_oe_a,
	output logic [ppi_pkg::PORT_W-1:0]         pin_out_b,
	output logic [ppi_pkg::PORT_W-1:0]         pin_oe_b,
	output logic [ppi_pkg::PORT_W-1:0]         pin_out_c,
	output logic [ppi_pkg::PORT_W-1:0]         pin_oe_c,
	output logic [ppi_pkg::PORT_W-1:0]         pull_on_a,
	output logic [ppi_pkg::PORT_W-1:0]         pull_on_b,
	output logic [ppi_pkg::PORT_W-1:0]         pull_on_c,
	output logic [ppi_pkg::PORT_W-1:0]         pull_down_a,
	output logic [ppi_pkg::PORT_W-1:0]         pull_down_b,
	output logic [ppi_pkg::PORT_W-1:0]         pull_down_c,
	output logic [ppi_pkg::PORT_W-1:0]         slew_on_a,
	output logic [ppi_pkg::PORT_W-1:0]         slew_on_b,
	output logic [ppi_pkg::PORT_W-1:0]         slew_on_c,
	output logic [ppi_pkg::PORT_W-1:0]         high_drive_a,
	output logic [ppi_pkg::PORT_W-1:0]         high_drive_b,
	output logic [ppi_pkg::PORT_W-1:0]         high_drive_c,
	output logic [ppi_pkg::PORT_W-1:0]         port_read_a,
	output logic [ppi_pkg::PORT_W-1:0]         port_read_b,
	output logic [ppi_pkg::PORT_W-1:0]         port_read_c,
	output logic [ppi_pkg::NUM_PORTS-1:0]      port_irq_flag,
	output logic [ppi_pkg::NUM_PORTS-1:0]      port_irq_enable_rd,
	output logic [ppi_pkg::NUM_PORTS-1:0]      detect_mode_rd,
	output logic [ppi_pkg::NUM_PORTS-1:0]      ack_read,
	output logic [ppi_pkg::NUM_PORTS-1:0]      irq_request,
	output logic                               wake_request
);
	import ppi_pkg::*;

	localparam logic [7:0] CAP [NUM_PORTS] = '{IRQ_CAP_A, IRQ_CAP_B,
		IRQ_CAP_C};

	logic [PORT_W-1:0] data_out     [NUM_PORTS];
	logic [PORT_W-1:0] direction    [NUM_PORTS];
	logic [PORT_W-1:0] pull_enable  [NUM_PORTS];
	logic [PORT_W-1:0] slew_enable  [NUM_PORTS];
	logic [PORT_W-1:0] drive_sel    [NUM_PORTS];
	logic [PORT_W-1:0] irq_select   [NUM_PORTS];
	logic [PORT_W-1:0] polarity     [NUM_PORTS];
	logic [PORT_W-1:0] pin_in       [NUM_PORTS];
	logic [PORT_W-1:0] own          [NUM_PORTS];
	logic [PORT_W-1:0] p_oe         [NUM_PORTS];
	logic [PORT_W-1:0] p_out        [NUM_PORTS];
	logic [PORT_W-1:0] oe           [NUM_PORTS];
	logic [PORT_W-1:0] out          [NUM_PORTS];
	logic [PORT_W-1:0] pull         [NUM_PORTS];
	logic [PORT_W-1:0] pdown        [NUM_PORTS];
	logic [PORT_W-1:0] rd           [NUM_PORTS];
	logic [NUM_PORTS-1:0] detect_mode;
	logic [NUM_PORTS-1:0] irq_enable;

	// per bit: first operand where sel is set, else second
	function automatic logic [PORT_W-1:0] bit_mux(
		input logic [PORT_W-1:0] sel,
		input logic [PORT_W-1:0] when_set,
		input logic [PORT_W-1:0] when_clear
	);
		return (sel & when_set) | (~sel & when_clear);
	endfunction

	assign pin_in = '{pin_in_a, pin_in_b, pin_in_c};
	assign own    = '{periph_own_a, periph_own_b, periph_own_c};
	assign p_oe   = '{periph_oe_a, periph_oe_b, periph_oe_c};
	assign p_out  = '{periph_out_a, periph_out_b, periph_out_c};

	// output data latches
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				data_out[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					data_out[i] <= wr_data_out;
				end
			end
		end
	end

	// data direction, inputs after reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				direction[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					direction[i] <= wr_direction;
				end
			end
		end
	end

	// pull enables, off after reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				pull_enable[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					pull_enable[i] <= wr_pull_enable;
				end
			end
		end
	end

	// slew rate control enables
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				slew_enable[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					slew_enable[i] <= wr_slew_enable;
				end
			end
		end
	end

	// drive strength selects
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				drive_sel[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					drive_sel[i] <= wr_drive_strength;
				end
			end
		end
	end

	// interrupt pin selects, masked to capable pins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				irq_select[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					irq_select[i] <= wr_pin_irq_select & CAP[i];
				end
			end
		end
	end

	// edge and level polarity per pin
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				polarity[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					polarity[i] <= wr_edge_polarity;
				end
			end
		end
	end

	// detection mode per port
	always_ff @(posedge core_clk) begin
		if (reset) begin
			detect_mode <= '0;
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					detect_mode[i] <= wr_detect_mode;
				end
			end
		end
	end

	// interrupt enable per port
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_enable <= '0;
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (ctrl_write[i]) begin
					irq_enable[i] <= wr_irq_enable;
				end
			end
		end
	end

	// pad control per port
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			oe[i]   = bit_mux(own[i], p_oe[i], direction[i]);
			out[i]  = bit_mux(own[i], p_out[i], data_out[i]);
			pull[i] = pull_enable[i] & ~oe[i];
			// pull-down only on rising-polarity interrupt pins
			pdown[i] = pull[i] & irq_select[i] & polarity[i];
			// direction bit picks latch or pin on read
			rd[i] = bit_mux(direction[i], data_out[i], pin_in[i]);
		end
	end

	assign pin_oe_a     = oe[PORT_A];
	assign pin_oe_b     = oe[PORT_B];
	assign pin_oe_c     = oe[PORT_C];
	assign pin_out_a    = out[PORT_A];
	assign pin_out_b    = out[PORT_B];
	assign pin_out_c    = out[PORT_C];
	assign pull_on_a    = pull[PORT_A];
	assign pull_on_b    = pull[PORT_B];
	assign pull_on_c    = pull[PORT_C];
	assign pull_down_a  = pdown[PORT_A];
	assign pull_down_b  = pdown[PORT_B];
	assign pull_down_c  = pdown[PORT_C];
	assign slew_on_a    = slew_enable[PORT_A] & oe[PORT_A];
	assign slew_on_b    = slew_enable[PORT_B] & oe[PORT_B];
	assign slew_on_c    = slew_enable[PORT_C] & oe[PORT_C];
	assign high_drive_a = drive_sel[PORT_A] & oe[PORT_A];
	assign high_drive_b = drive_sel[PORT_B] & oe[PORT_B];
	assign high_drive_c = drive_sel[PORT_C] & oe[PORT_C];
	assign port_read_a  = rd[PORT_A];
	assign port_read_b  = rd[PORT_B];
	assign port_read_c  = rd[PORT_C];
	assign port_irq_enable_rd = irq_enable;
	assign detect_mode_rd     = detect_mode;
	assign ack_read           = '0;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : gen_port
			ppi_port_irq #(
				.CAPABLE(CAP[g])
			) u_irq (
				.core_clk             (core_clk),
				.reset                (reset),
				.pin_in               (pin_in[g]),
				.pin_irq_select_reg   (irq_select[g]),
				.edge_polarity_bit    (polarity[g]),
				.detect_mode_bit      (detect_mode[g]),
				.port_irq_enable      (irq_enable[g]),
				.port_irq_acknowledge (port_irq_acknowledge[g]),
				.port_irq_flag        (port_irq_flag[g]),
				.irq_request          (irq_request[g])
			);
		end
	endgenerate

	// wake from low power while any request stands
	assign wake_request = (power_mode == PPI_WAIT ||
		power_mode == PPI_STOP3) && (|irq_request);
endmodule

// file: ppi_pkg.sv
// constants and types for the port pin interrupt block
package ppi_pkg;
	localparam int          PORT_W       = 8;
	localparam int          NUM_PORTS    = 3;
	localparam int          PORT_A       = 0;
	localparam int          PORT_B       = 1;
	localparam int          PORT_C       = 2;
	localparam logic [7:0]  IRQ_CAP_A    = 8'h0f;
	localparam logic [7:0]  IRQ_CAP_B    = 8'h0f;
	localparam logic [7:0]  IRQ_CAP_C    = 8'hff;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic        MODE_EDGE    = 1'b0;
	localparam logic        MODE_LEVEL   = 1'b1;
	localparam logic        POL_FALL     = 1'b0;
	localparam logic        POL_RISE     = 1'b1;
	typedef enum logic [1:0] {
		PPI_RUN,
		PPI_WAIT,
		PPI_STOP3
	} ppi_power_t;
endpackage

// file: ppi_port_irq.sv
// one port's pin interrupt detection, flag and request
module ppi_port_irq #(
	parameter logic [7:0] CAPABLE = 8'hff
) (
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic [ppi_pkg::PORT_W-1:0] pin_in,
	input  wire logic [ppi_pkg::PORT_W-1:0] pin_irq_select_reg,
	input  wire logic [ppi_pkg::PORT_W-1:0] edge_polarity_bit,
	input  wire logic                     detect_mode_bit,
	input  wire logic                     port_irq_enable,
	input  wire logic                     port_irq_acknowledge,
	output logic                          port_irq_flag,
	output logic                          irq_request
);
	import ppi_pkg::*;

	logic [PORT_W-1:0] enabled;
	logic [PORT_W-1:0] asserted;
	logic [PORT_W-1:0] prev_asserted;
	logic [PORT_W-1:0] armed;
	logic [PORT_W-1:0] edge_hit;
	logic              level_hit;
	logic              set_flag;
	logic              clear_ok;

	assign enabled   = pin_irq_select_reg & CAPABLE;
	// asserted = low for falling, high for rising
	assign asserted  = pin_in ~^ edge_polarity_bit;
	// previous sample deasserted, this one asserted
	assign edge_hit  = enabled & armed & ~prev_asserted & asserted;
	assign level_hit = |(enabled & asserted);
	assign set_flag  = (|edge_hit) ||
		(detect_mode_bit == MODE_LEVEL && level_hit);
	assign clear_ok  = port_irq_acknowledge &&
		(detect_mode_bit == MODE_EDGE || !level_hit);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			prev_asserted <= '0;
		end else begin
			prev_asserted <= asserted;
		end
	end

	// a pin must be seen deasserted while enabled before edges count
	always_ff @(posedge core_clk) begin
		if (reset) begin
			armed <= '0;
		end else begin
			armed <= enabled & (armed | ~asserted);
		end
	end

	// set wins over a coincident acknowledge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			port_irq_flag <= 1'b0;
		end else if (set_flag) begin
			port_irq_flag <= 1'b1;
		end else if (clear_ok) begin
			port_irq_flag <= 1'b0;
		end
	end

	assign irq_request = port_irq_flag & port_irq_enable;
endmodule

// file: ppi_monitor.sv
// concurrent checks on the port pin interrupt top ports
module ppi_monitor (
	input wire logic               core_clk,
	input wire logic               reset,
	input wire ppi_pkg::ppi_power_t power_mode,
	input wire logic [2:0]         port_irq_acknowledge,
	input wire logic [7:0]         periph_own_a,
	input wire logic [7:0]         periph_oe_a,
	input wire logic [7:0]         pin_oe_a,
	input wire logic [7:0]         pull_on_a,
	input wire logic [7:0]         pull_down_a,
	input wire logic [7:0]         slew_on_a,
	input wire logic [2:0]         port_irq_flag,
	input wire logic [2:0]         port_irq_enable_rd,
	input wire logic [2:0]         ack_read,
	input wire logic [2:0]         irq_request,
	input wire logic               wake_request
);
	timeunit 1ns;
	timeprecision 1ns;
	import ppi_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	ack_reads_zero_a: assert property (ack_read == 3'h0)
		else $error("ack read not zero");
	irq_request_a: assert property (
		irq_request == (port_irq_flag & port_irq_enable_rd))
		else $error("irq request wrong");
	wake_request_a: assert property (
		wake_request == ((|irq_request) && power_mode != PPI_RUN))
		else $error("wake request wrong");
	reset_clear_a: assert property (disable iff (1'b0)
		reset |=> port_irq_flag == 3'h0 && pin_oe_a == 8'h00
		&& pull_on_a == 8'h00) else $error("reset state wrong");
	ack_clear_a: assert property (
		!$past(reset) |-> (~port_irq_flag & $past(port_irq_flag)
		& ~$past(port_irq_acknowledge)) == 3'h0)
		else $error("flag fell without ack");
	owned_oe_a: assert property (
		(pin_oe_a & periph_own_a) == (periph_oe_a & periph_own_a))
		else $error("owned pin oe wrong");
	slew_gate_a: assert property ((slew_on_a & ~pin_oe_a) == 8'h00)
		else $error("slew on for input");
	pull_gate_a: assert property ((pull_on_a & pin_oe_a) == 8'h00
		&& (pull_down_a & ~pull_on_a) == 8'h00)
		else $error("pull on for output");
	cover property ($rose(port_irq_flag[0]));
	cover property ($fell(port_irq_flag[1]));
	cover property (wake_request);
endmodule
bind ppi_top ppi_monitor u_mon (
	.core_clk             (core_clk),
	.reset                (reset),
	.power_mode           (power_mode),
	.port_irq_acknowledge (port_irq_acknowledge),
	.periph_own_a         (periph_own_a),
	.periph_oe_a          (periph_oe_a),
	.pin_oe_a             (pin_oe_a),
	.pull_on_a            (pull_on_a),
	.pull_down_a          (pull_down_a),
	.slew_on_a            (slew_on_a),
	.port_irq_flag        (port_irq_flag),
	.port_irq_enable_rd   (port_irq_enable_rd),
	.ack_read             (ack_read),
	.irq_request          (irq_request),
	.wake_request         (wake_request)
);

// file: ppi_pins.sv
// pin level sources outside the three ports
module ppi_pins (
	input  wire logic [7:0] lvl_a,
	input  wire logic [7:0] lvl_b,
	input  wire logic [7:0] lvl_c,
	output logic [7:0]      pin_in_a,
	output logic [7:0]      pin_in_b,
	output logic [7:0]      pin_in_c
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_in_a = lvl_a;
	assign pin_in_b = lvl_b;
	assign pin_in_c = lvl_c;
endmodule

// file: ppi_top_tb.sv
// self-checking bench for the port pin interrupt top
module ppi_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ppi_pkg::*;
	logic       core_clk = 1'b0;
	logic       reset = 1'b1;
	ppi_power_t power_mode = PPI_RUN;
	logic [7:0] lvl_a = 8'hff, lvl_b = 8'hff, lvl_c = 8'h80;
	logic [7:0] pin_in_a, pin_in_b, pin_in_c, oe_a, pull_a, rd_a;
	logic [7:0] out_a, hd_a, sl_a, pd_c, rd_c;
	logic [2:0] mode_rd, ie_rd;
	logic [2:0] ctrl_write = 3'h0, ack = 3'h0, flag, irq;
	logic [7:0] w_dat = 8'h58, w_dir = 8'h02, w_pull = 8'hff;
	logic [7:0] w_sel = 8'h00, w_pol = 8'h00, own = 8'h00, poe = 8'h00;
	logic       w_mode = 1'b0, w_ie = 1'b0, wake;
	int         miscompares = 0, checked = 0;
	ppi_pins u_pins (.lvl_a, .lvl_b, .lvl_c, .pin_in_a, .pin_in_b, .pin_in_c);
	ppi_top u_dut (.core_clk, .reset, .power_mode, .pin_in_a, .pin_in_b,
		.pin_in_c, .ctrl_write, .wr_data_out(w_dat), .wr_direction(w_dir),
		.wr_pull_enable(w_pull), .wr_slew_enable(w_pull),
		.wr_drive_strength(w_pull), .wr_pin_irq_select(w_sel),
		.wr_edge_polarity(w_pol), .wr_detect_mode(w_mode),
		.wr_irq_enable(w_ie), .port_irq_acknowledge(ack),
		.periph_own_a(own), .periph_oe_a(poe), .periph_out_a(poe),
		.periph_own_b(own), .periph_oe_b(poe), .periph_out_b(poe),
		.periph_own_c(own), .periph_oe_c(poe), .periph_out_c(poe),
		.pin_out_a(out_a), .pin_oe_a(oe_a), .pin_out_b(), .pin_oe_b(),
		.pin_out_c(), .pin_oe_c(), .pull_on_a(pull_a), .pull_on_b(),
		.pull_on_c(), .pull_down_a(), .pull_down_b(), .pull_down_c(pd_c),
		.slew_on_a(sl_a), .slew_on_b(), .slew_on_c(), .high_drive_a(hd_a),
		.high_drive_b(), .high_drive_c(), .port_read_a(rd_a),
		.port_read_b(), .port_read_c(rd_c), .port_irq_flag(flag),
		.port_irq_enable_rd(ie_rd), .detect_mode_rd(mode_rd), .ack_read(),
		.irq_request(irq), .wake_request(wake));
	initial forever #10 core_clk = ~core_clk;
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cfg(int p, logic [7:0] sel, pol, logic m, ie);
		w_sel = sel;
		w_pol = pol;
		w_mode = m;
		w_ie = ie;
		ctrl_write[p] = 1'b1;
		tick();
		ctrl_write = 3'h0;
		tick();
	endtask
	task automatic ackp(int p);
		ack[p] = 1'b1;
		tick();
		ack = 3'h0;
		tick();
	endtask
	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		finish_test();
	end
	initial begin
		tick(2);
		reset = 1'b0;
		chk("oe_a", 8'h00, oe_a);
		chk("pull_a", 8'h00, pull_a);
		chk("flag", 8'h00, {5'h0, flag});
		cfg(0, 8'hff, 8'h00, MODE_EDGE, 1'b1);
		chk("pull_a", 8'hfd, pull_a);
		chk("read_a", 8'hfd, rd_a);
		chk("out_a", 8'h58, out_a);
		chk("drive_a", 8'h02, hd_a);
		chk("slew_a", 8'h02, sl_a);
		lvl_a = 8'hdf;
		tick(3);
		chk("flag", 8'h00, {5'h0, flag});
		lvl_a = 8'hde;
		tick(3);
		chk("flag", 8'h01, {5'h0, flag});
		chk("irq", 8'h01, {5'h0, irq});
		for (int m = 2; m >= 0; m--) begin
			power_mode = ppi_power_t'(m);
			tick();
			chk("wake", {7'h0, m != 0}, {7'h0, wake});
		end
		ackp(0);
		chk("flag", 8'h00, {5'h0, flag});
		own = 8'h04;
		poe = 8'h04;
		tick();
		chk("oe_a", 8'h06, oe_a);
		chk("pull_a", 8'hf9, pull_a);
		chk("out_a", 8'h5c, out_a);
		chk("slew_a", 8'h06, sl_a);
		own = 8'h00;
		cfg(2, 8'h80, 8'h80, MODE_EDGE, 1'b1);
		tick(2);
		chk("flag", 8'h00, {5'h0, flag});
		chk("pdown_c", 8'h80, pd_c);
		chk("read_c", 8'h80, rd_c);
		lvl_c = 8'h00;
		tick(3);
		lvl_c = 8'h80;
		tick(3);
		chk("flag", 8'h04, {5'h0, flag});
		cfg(1, 8'h01, 8'h00, MODE_LEVEL, 1'b0);
		lvl_b = 8'hfe;
		tick(3);
		chk("flag", 8'h06, {5'h0, flag});
		chk("irq", 8'h04, {5'h0, irq});
		chk("mode_rd", 8'h02, {5'h0, mode_rd});
		chk("ie_rd", 8'h05, {5'h0, ie_rd});
		ackp(1);
		chk("flag", 8'h06, {5'h0, flag});
		lvl_b = 8'hff;
		tick(2);
		ackp(1);
		chk("flag", 8'h04, {5'h0, flag});
		finish_test();
	end
endmodule
